/* hdl/smb_crc8.sv */
// module: running crc-8 over the bytes of one transaction
`timescale 1ns/1ps
module smb_crc8 (
    input logic ref_clk,
    input logic sys_rst,
    smb_core_if.crc_unit bus
);
    typedef struct packed {
        logic [7:0] crc;
    } crc_s;

    crc_s st;
    crc_s next_st;

    // one byte folded in per call, msb first
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ((x << 1) ^ smb_pkg::CRC_POLY) : (x << 1);
        end
        return x;
    endfunction : crc_step

    // clear at frame start, fold on each byte
    always_comb begin
        next_st = st;
        if (bus.crc_clr) begin
            next_st.crc = smb_pkg::CRC_INIT;
        end else if (bus.crc_feed) begin
            next_st.crc = crc_step(st.crc, bus.crc_din);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.crc = st.crc;
endmodule : smb_crc8

/* hdl/smb_reg_slave.sv */
// module: smbus slave that sets up and launches internal register access
`timescale 1ns/1ps
// Function
// - address from straps latched at power good
// - six byte/word/block read and write transfers
// - crc-8 checking optional, chosen per transaction
// - command bit 7 opens a sequence
// - command bit 6 closes a sequence
// - command bit 5 picks memory or configuration
// - command bit 4 adds crc byte
// - bits 3:2 internal operation, naturally aligned
// - bits 1:0 transfer type gives length
// - config: bus, devfn, 12-bit register number
// - memory: space byte, 24-bit offset, low 12
// - access launched only by final setup write
// - stretch clock until read data returns
// - stretch clock until write completes
// - timeout or abort nacks final write
// - internal reads are whole dwords only
// - read returns status then previous read data
// - status bits timeout, aborts and success
// - config space reaches every register; memory only the low 12 offset bits
// - bad crc byte nacked, no access
// - 25 ms cumulative low resets slave
// - 50 ms continuous high resets slave
module smb_reg_slave #(
    parameter logic [smb_pkg::CNT_W-1:0] T_ACC_CYC = smb_pkg::ACC_TOUT_CYC,
    parameter logic [smb_pkg::CNT_W-1:0] T_LOW_CYC = smb_pkg::LOW_TOUT_CYC,
    parameter logic [smb_pkg::CNT_W-1:0] T_HIGH_CYC = smb_pkg::HIGH_TOUT_CYC
) (
    input logic ref_clk,
    input logic sys_rst,
    input logic power_good,
    input logic [3:0] addr_strap,
    input logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic acc_req,
    output logic acc_mem,
    output smb_pkg::icmd_e acc_cmd,
    output logic [7:0] acc_bus,
    output logic [7:0] acc_devfn,
    output logic [7:0] acc_dest,
    output logic [11:0] acc_addr,
    output logic [31:0] acc_wdata,
    input logic acc_done,
    input logic [31:0] acc_rdata,
    input logic acc_mabort,
    input logic acc_tabort,
    output logic [6:0] slave_addr,
    output logic [7:0] last_status
);
    typedef struct packed {
        logic pg_m;
        logic pg_q;
        logic pg_p;
        logic [3:0] strap_m;
        logic [3:0] strap_q;
        logic scl_m;
        logic scl_q;
        logic scl_p;
        logic sda_m;
        logic sda_q;
        logic sda_p;
        logic [6:0] addr;
        smb_pkg::phase_e ph;
        logic [3:0] bitn;
        logic tx;
        logic mack;
        logic frame;
        logic crc_on;
        logic cntp;
        logic pec_sent;
        logic sda_oe;
        logic scl_oe;
        logic [7:0] txb;
        smb_pkg::cmd_s cmd;
        logic [7:0] cnt;
        logic [2:0] wptr;
        logic [2:0] rptr;
        logic [smb_pkg::BUF_N-1:0][7:0] buf_b;
        logic [7:0] status;
        logic [31:0] rdata;
        logic [smb_pkg::CNT_W-1:0] tcnt;
        logic [smb_pkg::CNT_W-1:0] lcnt;
        logic [smb_pkg::CNT_W-1:0] hcnt;
        logic req;
        logic amem;
        smb_pkg::icmd_e acmd;
        logic [11:0] aaddr;
        logic crc_clr;
        logic crc_feed;
        logic [7:0] crc_din;
    } state_s;

    state_s st;
    state_s next_st;
    logic start_seen;
    logic stop_seen;
    logic rise;
    logic fall;
    logic [7:0] tb;
    logic ack;
    logic ok;
    smb_pkg::cmd_s c;

    smb_core_if bus();

    // bytes expected from the transfer type
    function automatic logic [7:0] xfer_len(input smb_pkg::cmd_s k);
        logic [7:0] len;
        len = smb_pkg::LEN_BYTE;
        if (k.xfer == smb_pkg::XT_WORD) begin
            len = smb_pkg::LEN_WORD;
        end else if (k.xfer == smb_pkg::XT_BLOCK) begin
            len = smb_pkg::RD_LEN;
        end
        return len;
    endfunction : xfer_len

    // read payload: status byte, then dword low byte first
    function automatic logic [7:0] rd_byte(input logic [7:0] s,
                                           input logic [31:0] d,
                                           input logic [2:0] ix);
        logic [7:0] v;
        v = smb_pkg::FILL_BYTE;
        unique case (ix)
            3'h0: v = s;
            3'h1: v = d[7:0];
            3'h2: v = d[15:8];
            3'h3: v = d[23:16];
            3'h4: v = d[31:24];
            default: v = smb_pkg::FILL_BYTE;
        endcase
        return v;
    endfunction : rd_byte

    // natural alignment to the access width
    function automatic logic [11:0] align(input smb_pkg::icmd_e op,
                                          input logic [11:0] a);
        logic [11:0] v;
        v = {a[11:2], 2'h0};
        if (op == smb_pkg::IC_WR_B) begin
            v = a;
        end else if (op == smb_pkg::IC_WR_W) begin
            v = {a[11:1], 1'h0};
        end
        return v;
    endfunction : align

    smb_shift u_shift (
        .scl_clk(scl_in),
        .sys_rst(sys_rst),
        .bus(bus)
    );

    smb_crc8 u_crc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus(bus)
    );

    // bus conditions seen on synchronised lines
    assign start_seen = st.scl_q && st.scl_p && st.sda_p && !st.sda_q;
    assign stop_seen = st.scl_q && st.scl_p && !st.sda_p && st.sda_q;
    assign rise = st.scl_q && !st.scl_p;
    assign fall = !st.scl_q && st.scl_p;

    // next state of the whole slave
    always_comb begin
        next_st = st;
        tb = smb_pkg::FILL_BYTE;
        ack = 1'b0;
        ok = 1'b0;
        c = smb_pkg::cmd_s'(bus.shreg);
        next_st.crc_clr = 1'b0;
        next_st.crc_feed = 1'b0;
        next_st.crc_din = bus.shreg;
        next_st.pg_m = power_good;
        next_st.pg_q = st.pg_m;
        next_st.pg_p = st.pg_q;
        next_st.strap_m = addr_strap;
        next_st.strap_q = st.strap_m;
        next_st.scl_m = scl_in;
        next_st.scl_q = st.scl_m;
        next_st.scl_p = st.scl_q;
        next_st.sda_m = sda_in;
        next_st.sda_q = st.sda_m;
        next_st.sda_p = st.sda_q;
        if (st.pg_q && !st.pg_p) begin
            next_st.addr = {smb_pkg::ADDR_B7, smb_pkg::ADDR_B6,
                st.strap_q[3], smb_pkg::ADDR_B4, st.strap_q[2:0]};
        end
        // bus idle and low time counters
        next_st.hcnt = st.scl_q ? st.hcnt + 1'b1 : '0;
        if (st.frame && !st.scl_q && !st.scl_oe) begin
            next_st.lcnt = st.lcnt + 1'b1;
        end
        if (start_seen) begin
            next_st.frame = 1'b1;
            next_st.ph = smb_pkg::PH_ADDR;
            next_st.bitn = '0;
            next_st.tx = 1'b0;
            next_st.sda_oe = 1'b0;
            if (!st.frame) begin
                next_st.crc_clr = 1'b1;
                next_st.lcnt = '0;
            end
        end else if (stop_seen) begin
            next_st.frame = 1'b0;
            next_st.ph = smb_pkg::PH_IDLE;
            next_st.tx = 1'b0;
            next_st.sda_oe = 1'b0;
            next_st.lcnt = '0;
        end else if (rise) begin
            next_st.bitn = st.bitn + 4'h1;
            if (st.bitn == smb_pkg::BIT_ACK && st.tx) begin
                next_st.mack = !st.sda_q;
            end
        end else if (fall) begin
            if (st.bitn == smb_pkg::BIT_ACK && st.tx) begin
                next_st.sda_oe = 1'b0;
            end else if (st.bitn == smb_pkg::BIT_ACK) begin
                next_st.crc_feed = 1'b1;
                unique case (st.ph)
                    smb_pkg::PH_ADDR: begin
                        if (bus.shreg[7:1] == st.addr) begin
                            ack = 1'b1;
                            if (bus.shreg[0]) begin
                                next_st.ph = smb_pkg::PH_RD;
                                next_st.cntp =
                                    st.cmd.xfer == smb_pkg::XT_BLOCK;
                                next_st.cnt = xfer_len(st.cmd);
                                next_st.pec_sent = 1'b0;
                            end else begin
                                next_st.ph = smb_pkg::PH_CMD;
                            end
                        end else begin
                            next_st.ph = smb_pkg::PH_IGN;
                        end
                    end
                    smb_pkg::PH_CMD: begin
                        next_st.cmd = c;
                        next_st.crc_on = c.crc_check_on;
                        next_st.cnt = xfer_len(c);
                        ack = c.xfer != smb_pkg::XT_RSVD;
                        if (c.first) begin
                            next_st.wptr = '0;
                            next_st.rptr = '0;
                        end
                        if (c.xfer == smb_pkg::XT_RSVD) begin
                            next_st.ph = smb_pkg::PH_IGN;
                        end else if (c.xfer == smb_pkg::XT_BLOCK) begin
                            next_st.ph = smb_pkg::PH_CNT;
                        end else begin
                            next_st.ph = smb_pkg::PH_DATA;
                        end
                    end
                    smb_pkg::PH_CNT: begin
                        ack = 1'b1;
                        next_st.cnt = bus.shreg;
                        if (bus.shreg != '0) begin
                            next_st.ph = smb_pkg::PH_DATA;
                        end else if (st.crc_on) begin
                            next_st.ph = smb_pkg::PH_PEC;
                        end else begin
                            next_st.ph = smb_pkg::PH_IGN;
                        end
                    end
                    smb_pkg::PH_DATA: begin
                        next_st.buf_b[st.wptr] = bus.shreg;
                        if (st.wptr != smb_pkg::IX_LAST) begin
                            next_st.wptr = st.wptr + 3'h1;
                        end
                        next_st.cnt = st.cnt - 8'h01;
                        ack = 1'b1;
                        if (st.cnt == smb_pkg::LEN_BYTE) begin
                            if (st.crc_on) begin
                                next_st.ph = smb_pkg::PH_PEC;
                            end else if (st.cmd.last) begin
                                ack = 1'b0;
                                next_st.ph = smb_pkg::PH_STRETCH;
                            end else begin
                                next_st.ph = smb_pkg::PH_IGN;
                            end
                        end
                    end
                    smb_pkg::PH_PEC: begin
                        ok = bus.shreg == bus.crc;
                        if (!ok) begin
                            next_st.ph = smb_pkg::PH_IGN;
                        end else if (st.cmd.last) begin
                            next_st.ph = smb_pkg::PH_STRETCH;
                        end else begin
                            ack = 1'b1;
                            next_st.ph = smb_pkg::PH_IGN;
                        end
                    end
                    default: ack = 1'b0;
                endcase
                next_st.sda_oe = ack;
            end else if (st.bitn == smb_pkg::BIT_DONE) begin
                next_st.bitn = '0;
                next_st.sda_oe = 1'b0;
                if ((st.tx && st.mack) ||
                    (!st.tx && st.ph == smb_pkg::PH_RD)) begin
                    // next read byte: count, payload, then crc
                    next_st.tx = 1'b1;
                    next_st.crc_feed = 1'b1;
                    if (st.cntp) begin
                        tb = smb_pkg::RD_LEN;
                        next_st.cntp = 1'b0;
                    end else if (st.cnt != '0) begin
                        tb = rd_byte(st.status, st.rdata, st.rptr);
                        next_st.rptr = st.rptr + 3'h1;
                        next_st.cnt = st.cnt - 8'h01;
                    end else if (st.crc_on && !st.pec_sent) begin
                        tb = bus.crc;
                        next_st.pec_sent = 1'b1;
                        next_st.crc_feed = 1'b0;
                    end
                    next_st.txb = tb;
                    next_st.crc_din = tb;
                    next_st.sda_oe = !tb[7];
                end else if (st.tx) begin
                    next_st.tx = 1'b0;
                    next_st.ph = smb_pkg::PH_IGN;
                end
            end else if (st.tx) begin
                next_st.sda_oe = !st.txb[3'h7 - st.bitn[2:0]];
            end
        end
        // launch: clock held low while the access runs
        if (next_st.ph == smb_pkg::PH_STRETCH &&
            st.ph != smb_pkg::PH_STRETCH) begin
            next_st.scl_oe = 1'b1;
            next_st.req = 1'b1;
            next_st.tcnt = '0;
            next_st.amem = st.cmd.mem;
            next_st.acmd = st.cmd.icmd;
            if (st.cmd.mem) begin
                next_st.aaddr = align(st.cmd.icmd,
                    {next_st.buf_b[smb_pkg::IX_OFF_MID][3:0],
                     next_st.buf_b[smb_pkg::IX_OFF_LO]});
            end else begin
                next_st.aaddr = align(st.cmd.icmd,
                    {next_st.buf_b[smb_pkg::IX_REG_B][3:0],
                     next_st.buf_b[smb_pkg::IX_REG_A]});
            end
        end
        // finish: record status, answer ack or nack
        if (st.ph == smb_pkg::PH_STRETCH) begin
            next_st.tcnt = st.tcnt + 1'b1;
            if (acc_done || st.tcnt == T_ACC_CYC) begin
                next_st.req = 1'b0;
                next_st.status = '0;
                if (st.tcnt == T_ACC_CYC && !acc_done) begin
                    next_st.status[smb_pkg::ST_TOUT] = 1'b1;
                end else if (acc_mabort) begin
                    next_st.status[smb_pkg::ST_MABORT] = 1'b1;
                end else if (acc_tabort) begin
                    next_st.status[smb_pkg::ST_TABORT] = 1'b1;
                end else begin
                    next_st.status[smb_pkg::ST_OK] = 1'b1;
                    if (st.acmd == smb_pkg::IC_RD_DW) begin
                        next_st.rdata = acc_rdata;
                    end
                end
                next_st.sda_oe = next_st.status[smb_pkg::ST_OK];
                next_st.ph = smb_pkg::PH_REL;
            end
        end
        if (st.ph == smb_pkg::PH_REL) begin
            next_st.scl_oe = 1'b0;
            next_st.ph = smb_pkg::PH_IGN;
        end
        // bus timeouts drop the slave back to idle
        if (st.lcnt >= T_LOW_CYC || st.hcnt >= T_HIGH_CYC) begin
            next_st.ph = smb_pkg::PH_IDLE;
            next_st.frame = 1'b0;
            next_st.tx = 1'b0;
            next_st.sda_oe = 1'b0;
            next_st.lcnt = '0;
            next_st.hcnt = '0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // crc unit and pins
    assign bus.sda_in = sda_in;
    assign bus.crc_clr = st.crc_clr;
    assign bus.crc_feed = st.crc_feed;
    assign bus.crc_din = st.crc_din;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = st.scl_oe;
    assign sda_oe = st.sda_oe;

    // internal access request and observed state
    assign acc_req = st.req;
    assign acc_mem = st.amem;
    assign acc_cmd = st.acmd;
    assign acc_addr = st.aaddr;
    assign acc_bus = st.buf_b[smb_pkg::IX_BUS];
    assign acc_devfn = st.buf_b[smb_pkg::IX_DEVFN];
    assign acc_dest = st.buf_b[smb_pkg::IX_DEST];
    assign acc_wdata = st.buf_b[smb_pkg::IX_DATA_HI:smb_pkg::IX_DATA_LO];
    assign slave_addr = st.addr;
    assign last_status = st.status;
endmodule : smb_reg_slave

/* hdl/smb_shift.sv */
// module: serial data shifter clocked by the bus clock
`timescale 1ns/1ps
module smb_shift (
    input logic scl_clk,
    input logic sys_rst,
    smb_core_if.shift bus
);
    typedef struct packed {
        logic [7:0] sh;
    } shift_s;

    shift_s st;
    shift_s next_st;

    // take one data bit per rising bus clock
    always_comb begin
        next_st.sh = {st.sh[6:0], bus.sda_in};
    end

    // byte stays still while the clock is low; core reads it then
    always_ff @(posedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.shreg = st.sh;
endmodule : smb_shift

/* pkg/smb_core_if.sv */
// interface: serial byte and crc signals between the slave's parts
`timescale 1ns/1ps
interface smb_core_if;
    logic sda_in;
    logic [7:0] shreg;
    logic crc_clr;
    logic crc_feed;
    logic [7:0] crc_din;
    logic [7:0] crc;
    modport shift (input sda_in, output shreg);
    modport crc_unit (input crc_clr, input crc_feed, input crc_din,
        output crc);
    modport ctrl (output sda_in, output crc_clr, output crc_feed,
        output crc_din, input shreg, input crc);
endinterface : smb_core_if

/* pkg/smb_pkg.sv */
// package: constants and types for the smbus register access slave
package smb_pkg;

    // reference clock and time limits
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned HZ_PER_KHZ = 1000;
    localparam int unsigned ACC_TOUT_MS = 2;
    localparam int unsigned LOW_TOUT_MS = 25;
    localparam int unsigned HIGH_TOUT_MS = 50;
    localparam int CNT_W = 21;
    localparam logic [CNT_W-1:0] ACC_TOUT_CYC =
        CNT_W'(ACC_TOUT_MS * (CLK_HZ / HZ_PER_KHZ));
    localparam logic [CNT_W-1:0] LOW_TOUT_CYC =
        CNT_W'(LOW_TOUT_MS * (CLK_HZ / HZ_PER_KHZ));
    localparam logic [CNT_W-1:0] HIGH_TOUT_CYC =
        CNT_W'(HIGH_TOUT_MS * (CLK_HZ / HZ_PER_KHZ));

    // serial framing: rise count at the ack slot and after it
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    // fixed bits of the 7-bit slave address
    localparam logic ADDR_B7 = 1'b1;
    localparam logic ADDR_B6 = 1'b1;
    localparam logic ADDR_B4 = 1'b0;

    // crc-8, polynomial x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // transfer lengths in bytes
    localparam logic [7:0] LEN_BYTE = 8'h01;
    localparam logic [7:0] LEN_WORD = 8'h02;
    localparam logic [7:0] RD_LEN = 8'h05;
    localparam logic [7:0] FILL_BYTE = 8'hff;

    // setup buffer slots
    localparam int BUF_N = 8;
    localparam logic [2:0] IX_LAST = 3'h7;
    localparam int IX_BUS = 0;
    localparam int IX_DEVFN = 1;
    localparam int IX_REG_A = 2;
    localparam int IX_REG_B = 3;
    localparam int IX_DEST = 0;
    localparam int IX_OFF_MID = 2;
    localparam int IX_OFF_LO = 3;
    localparam int IX_DATA_LO = 4;
    localparam int IX_DATA_HI = 7;

    // status byte bits
    localparam int ST_TOUT = 7;
    localparam int ST_MABORT = 5;
    localparam int ST_TABORT = 4;
    localparam int ST_OK = 0;

    typedef enum logic [1:0] {
        IC_RD_DW = 2'h0,
        IC_WR_B = 2'h1,
        IC_WR_W = 2'h2,
        IC_WR_DW = 2'h3
    } icmd_e;

    typedef enum logic [1:0] {
        XT_BYTE = 2'h0,
        XT_WORD = 2'h1,
        XT_BLOCK = 2'h2,
        XT_RSVD = 2'h3
    } xfer_e;

    // command byte layout, msb first
    typedef struct packed {
        logic first;
        logic last;
        logic mem;
        logic crc_check_on;
        icmd_e icmd;
        xfer_e xfer;
    } cmd_s;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h0,
        PH_ADDR = 4'h1,
        PH_CMD = 4'h3,
        PH_CNT = 4'h2,
        PH_DATA = 4'h6,
        PH_PEC = 4'h7,
        PH_STRETCH = 4'h5,
        PH_REL = 4'h4,
        PH_RD = 4'hc,
        PH_IGN = 4'hd
    } phase_e;

endpackage : smb_pkg

/* tb/smb_master.sv */
// model: smbus master bit-banging the open-drain lines
`timescale 1ns/1ps
module smb_master (
    output logic scl_m,
    output logic sda_m,
    input wire logic scl_in,
    input wire logic sda_in
);
    localparam time Q = 48 * 53; // quarter bit, just under 100 khz
    logic [7:0] crc = 8'h00;
    initial begin
        scl_m = 1;
        sda_m = 1;
    end
    // set both lines, hold a quarter bit
    task ph(input logic c, d);
        scl_m = c;
        sda_m = d;
        #Q;
    endtask : ph
    // one bit, waits out clock stretching
    task bt(input logic d, output logic s);
        ph(0, d);
        scl_m = 1;
        wait (scl_in);
        #Q;
        s = sda_in;
        #Q;
        ph(0, d);
    endtask : bt
    // start or repeated start, clock left low
    task start();
        ph(0, 1);
        ph(1, 1);
        ph(1, 0);
        ph(0, 0);
    endtask : start
    // stop ends the frame and its crc
    task stop();
        ph(0, 0);
        ph(1, 0);
        ph(1, 1);
        crc = 8'h00;
    endtask : stop
    // byte plus ack slot; a is the ack the master drives
    task xb(input logic [7:0] d, input logic a, output logic [7:0] q,
        output logic n);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(a, n);
        crc = crc ^ q;
        repeat (8) crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h07 : 8'h00);
    endtask : xb
endmodule : smb_master

/* tb/smb_reg_slave_asserts.sv */
// checker: access handshake, stretch and status relations
`timescale 1ns/1ps
module smb_reg_slave_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_oe,
    input wire logic acc_req,
    input wire logic acc_done,
    input wire logic acc_mabort,
    input wire logic acc_tabort,
    input wire logic [11:0] acc_addr,
    input wire logic [6:0] slave_addr,
    input wire logic [7:0] last_status
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // completion seen while a request is open
    wire fin = acc_req && acc_done;
    // request lifetime and clock stretching
    a_req_ends: assert property (fin |=> !acc_req)
        else $error("request kept");
    a_stretch_held: assert property (acc_req |-> scl_oe)
        else $error("no stretch");
    a_stretch_freed: assert property (fin |=> ##1 !scl_oe)
        else $error("stretch kept");
    a_args_held: assert property ($past(acc_req) |-> $stable(acc_addr))
        else $error("address moved");
    // status byte after each kind of completion
    a_status_ok: assert property (fin && !acc_mabort && !acc_tabort
        |=> last_status == 8'h01) else $error("bad ok status");
    a_status_mab: assert property (fin && acc_mabort
        |=> last_status == 8'h20) else $error("bad abort status");
    a_status_tab: assert property (fin && !acc_mabort && acc_tabort
        |=> last_status == 8'h10) else $error("bad target status");
    a_status_tout: assert property (acc_req && !acc_done ##1 !acc_req
        |-> last_status == 8'h80) else $error("bad timeout status");
    a_addr_fixed: assert property (slave_addr != 7'h00
        |-> slave_addr[6:5] == 2'h3 && !slave_addr[3]) else $error("bad addr");
endmodule : smb_reg_slave_asserts
bind smb_reg_slave smb_reg_slave_asserts smb_reg_slave_asserts_i (.*);

/* tb/smb_reg_slave_bench.sv */
// bench: setup writes, launched accesses and read-back
`timescale 1ns/1ps
module smb_reg_slave_bench;
    logic ref_clk = 0, sys_rst = 1, power_good = 0, acc_done = 0;
    logic acc_mabort = 0, acc_tabort = 0, scl_m, sda_m, scl_out, sda_out;
    logic scl_oe, sda_oe, acc_req, acc_mem, scl_in, sda_in;
    logic [3:0] addr_strap;
    logic [6:0] slave_addr, ea;
    logic [7:0] acc_bus, acc_devfn, acc_dest, last_status, r, c, k, b[8];
    logic [11:0] acc_addr;
    logic [15:0] nk;
    logic [31:0] acc_wdata, acc_rdata = 0, seed = 32'h1ebf;
    logic [47:0] got;
    smb_pkg::icmd_e acc_cmd;
    int fail_count = 0, total_checks = 0, mode = 0, dly = 0, starts = 0;
    assign scl_in = scl_m & ~scl_oe;
    assign sda_in = sda_m & ~sda_oe;
    smb_reg_slave #(.T_ACC_CYC(21'd40), .T_LOW_CYC(21'd60000),
        .T_HIGH_CYC(21'd4000)) smb_reg_slave_i (.*);
    smb_master smb_master_i (.*);
    // clock and launch counter
    always #20 ref_clk = ~ref_clk;
    always @(posedge acc_req) starts++;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task chk(input string nm, input logic [47:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task report_and_stop();
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // one write frame; flip corrupts the crc byte
    task wr(input logic [7:0] q[$], input logic p, input logic [7:0] flip);
        nk = 0;
        q.push_front({ea, 1'b0});
        smb_master_i.start();
        foreach (q[i]) smb_master_i.xb(q[i], 1, r, nk[i]);
        k = smb_master_i.crc ^ flip;
        if (p) smb_master_i.xb(k, 1, r, nk[q.size()]);
        smb_master_i.stop();
    endtask : wr
    // internal core answering after dly cycles, mode picks outcome
    always @(negedge ref_clk) begin
        acc_done <= 0;
        if (acc_req && !acc_done && dly > 0) dly <= dly - 1;
        else if (acc_req && !acc_done && mode < 3) begin
            acc_done <= 1;
            acc_mabort <= mode == 1;
            acc_tabort <= mode == 2;
            acc_rdata <= rnd();
        end
    end
    initial begin
        addr_strap = 4'(rnd());
        ea = {2'h3, addr_strap[3], 1'h0, addr_strap[2:0]};
        foreach (b[i]) b[i] = 8'(rnd());
        repeat (2) @(negedge ref_clk);
        sys_rst = 0;
        power_good = 1;
        repeat (9) @(negedge ref_clk);
        chk("addr", slave_addr, ea);
        // config dword read set up by one block write with crc
        dly = 5;
        wr('{8'hd2, 8'h04, b[0], b[1], b[2], b[3]}, 1, 0);
        chk("cfg", {nk, acc_mem, acc_cmd, acc_bus, acc_devfn},
            {19'h0, b[0], b[1]});
        chk("reg", acc_addr, {b[3][3:0], b[2][7:2], 2'h0});
        // block read of status and data, crc byte nacked
        smb_master_i.start();
        smb_master_i.xb({ea, 1'b0}, 1, r, nk[0]);
        smb_master_i.xb(8'hd2, 1, r, nk[0]);
        smb_master_i.start();
        smb_master_i.xb({ea, 1'b1}, 1, r, nk[0]);
        for (int i = 0; i < 6; i++) begin
            smb_master_i.xb(8'hff, 0, r, nk[0]);
            got = {r, got[47:8]};
        end
        c = smb_master_i.crc;
        smb_master_i.xb(8'hff, 1, r, nk[0]);
        smb_master_i.stop();
        chk("rd", got, {acc_rdata, 8'h01, 8'h05});
        chk("crc", r, c);
        // memory dword write answered by a master abort
        foreach (b[i]) b[i] = 8'(rnd());
        mode = 1;
        wr('{8'hee, 8'h08, b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]},
            0, 0);
        chk("mem", {nk, acc_mem, acc_cmd, acc_dest},
            {16'h0400, 3'h7, b[0]});
        chk("off", {acc_addr, acc_wdata}, {b[2][3:0], b[3][7:2], 2'h0,
            b[7], b[6], b[5], b[4]});
        // bad crc refused without launch, then a final write times out
        c = 8'(starts);
        wr('{8'hdc, b[0]}, 1, 8'hff);
        chk("pec", {nk, 8'(starts)}, {16'h0008, c});
        mode = 3;
        wr('{8'h6c, b[1]}, 0, 0);
        chk("tout", {nk, 8'(starts)}, {16'h0004, c + 8'h01});
        // target abort on a repeated final write
        mode = 2;
        wr('{8'h6c, b[2]}, 0, 0);
        chk("tab", {nk, last_status}, {16'h0004, 8'h10});
        report_and_stop();
    end
    // watchdog
    initial begin
        #4_000_000;
        fail_count++;
        report_and_stop();
    end
endmodule : smb_reg_slave_bench
